// File: logic/fop_pkg.sv
// Constants for the flash option, power and status register bank.
// Assumes a 16-bit register port on the system clock, word addresses.
package fop_pkg;

  // ==========================================================================
  // Register word addresses
  localparam logic [15:0] FOP_ADDR_OPTION = 16'h0A80;
  localparam logic [15:0] FOP_ADDR_POWER  = 16'h0A82;
  localparam logic [15:0] FOP_ADDR_STATE  = 16'h0A83;

  // ==========================================================================
  // Field positions
  localparam int FOP_BIT_PIPE_EN      = 0;
  localparam int FOP_BIT_FAULT        = 8;
  localparam int FOP_BIT_ACTIVE_WAIT  = 3;
  localparam int FOP_BIT_STDBY_WAIT   = 2;
  localparam int FOP_POWER_MSB        = 1;
  localparam int FOP_POWER_LSB        = 0;

  // ==========================================================================
  // Power mode encodings, ordered by rising power
  localparam logic [1:0] FOP_MODE_SLEEP    = 2'h0;
  localparam logic [1:0] FOP_MODE_STANDBY  = 2'h1;
  localparam logic [1:0] FOP_MODE_RESERVED = 2'h2;
  localparam logic [1:0] FOP_MODE_ACTIVE   = 2'h3;

  // ==========================================================================
  // Reset values
  localparam logic       FOP_RST_PIPE_EN = 1'h0;
  localparam logic [1:0] FOP_RST_POWER   = 2'h0;
  localparam logic [1:0] FOP_RST_CURRENT = 2'h0;
  localparam logic       FOP_RST_FAULT   = 1'h0;
  localparam logic [15:0] FOP_RST_RDATA  = 16'h0000;

  // ==========================================================================
  // Transition timing: wait counter width in bits, then waits in system clock cycles
  localparam int FOP_WAIT_W           = 9;
  localparam int FOP_STDBY_WAIT_CYC   = 511;
  localparam int FOP_ACTIVE_WAIT_CYC  = 511;

  typedef enum logic [1:0] {
    FOP_IDLE,
    FOP_WAIT_STDBY,
    FOP_WAIT_ACTIVE
  } fop_state_t;

endpackage

// File: logic/fop_flash_option_power_regs.sv
// Flash option, power request and status registers with power-up sequencing.
// Assumes a CPU register port on the same clock and a supply-fault pin from
// the charge pump that is asynchronous to it.
module fop_flash_option_power_regs
  import fop_pkg::*;
#(
  parameter int STDBY_WAIT  = FOP_STDBY_WAIT_CYC,
  parameter int ACTIVE_WAIT = FOP_ACTIVE_WAIT_CYC
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [15:0] regAddr,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [15:0] regWrData,
  output logic      [15:0] regRdData,
  input  wire logic        protectedWriteUnlock,
  input  wire logic        securityLocked,
  input  wire logic        supplyFaultPin,
  input  wire logic        fetchReq,
  input  wire logic        fetchInArray,
  output logic             fetchStall,
  output logic             prefetchActive,
  output logic             prefetchPipelineEnable,
  output logic      [1:0]  powerModeCurrent
);

  // ==========================================================================
  // Register state
  logic             prefetchEnable;
  logic [1:0]       powerModeRequest;
  logic [1:0]       currentMode;
  logic             supplyFaultSticky;
  logic             faultMeta;
  logic             faultSync;
  fop_state_t       state;
  fop_state_t       next_state;
  logic [FOP_WAIT_W-1:0] waitCount;

  localparam logic [FOP_WAIT_W-1:0] STDBY_LOAD  = FOP_WAIT_W'(STDBY_WAIT - 1);
  localparam logic [FOP_WAIT_W-1:0] ACTIVE_LOAD = FOP_WAIT_W'(ACTIVE_WAIT - 1);

  // ==========================================================================
  // Access decode
  wire accessOk    = ~securityLocked;
  wire writeOk     = regWrEn & protectedWriteUnlock & accessOk;
  wire hitOption   = (regAddr == FOP_ADDR_OPTION);
  wire hitPower    = (regAddr == FOP_ADDR_POWER);
  wire hitState    = (regAddr == FOP_ADDR_STATE);
  wire wrOption    = writeOk & hitOption;
  wire wrPower     = writeOk & hitPower
                   & (regWrData[FOP_POWER_MSB:FOP_POWER_LSB] != FOP_MODE_RESERVED);
  wire clearFault  = writeOk & hitState & regWrData[FOP_BIT_FAULT];

  wire sleepToStandbyCounting    = (state == FOP_WAIT_STDBY);
  wire standbyToActiveCounting   = (state == FOP_WAIT_ACTIVE);

  wire [15:0] optionView = {15'h0000, prefetchEnable};
  wire [15:0] powerView  = {14'h0000, powerModeRequest};
  wire [15:0] stateView  = {7'h00, supplyFaultSticky, 4'h0,
                            standbyToActiveCounting, sleepToStandbyCounting,
                            currentMode};
  wire [15:0] readMux    = hitOption ? optionView :
                           hitPower  ? powerView  :
                           hitState  ? stateView  : 16'h0000;

  // ==========================================================================
  // Power sequencing
  // An array fetch while not active wakes the array; drops take effect at once
  // but the next fetch then pays the wake delay from the lower mode, on ROM parts too.
  wire arrayFetch  = fetchReq & fetchInArray;
  wire wakeNeeded  = arrayFetch & (currentMode != FOP_MODE_ACTIVE);
  wire [1:0] goalMode = wakeNeeded ? FOP_MODE_ACTIVE : powerModeRequest;
  wire goUp        = (goalMode > currentMode);
  wire goDown      = (goalMode < currentMode);
  wire countDone   = (waitCount == {FOP_WAIT_W{1'b0}});
  wire wakeFinish  = standbyToActiveCounting & countDone;

  always_comb begin
    next_state = state;
    case (state)
      FOP_IDLE: begin
        if (goUp && currentMode == FOP_MODE_SLEEP) begin
          next_state = FOP_WAIT_STDBY;
        end else if (goUp) begin
          next_state = FOP_WAIT_ACTIVE;
        end
      end
      FOP_WAIT_STDBY: begin
        if (countDone) begin
          next_state = FOP_IDLE;
        end
      end
      FOP_WAIT_ACTIVE: begin
        if (countDone) begin
          next_state = FOP_IDLE;
        end
      end
      default: next_state = FOP_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= FOP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Counter loads on entry so the wait state lasts exactly the count
  always_ff @(posedge clock) begin
    if (srst) begin
      waitCount <= {FOP_WAIT_W{1'b0}};
    end else if (state == FOP_IDLE && next_state == FOP_WAIT_STDBY) begin
      waitCount <= STDBY_LOAD;
    end else if (state == FOP_IDLE && next_state == FOP_WAIT_ACTIVE) begin
      waitCount <= ACTIVE_LOAD;
    end else if (!countDone) begin
      waitCount <= waitCount - 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      currentMode <= FOP_RST_CURRENT;
    end else if (sleepToStandbyCounting && countDone) begin
      currentMode <= FOP_MODE_STANDBY;
    end else if (wakeFinish) begin
      currentMode <= FOP_MODE_ACTIVE;
    end else if (state == FOP_IDLE && goDown) begin
      currentMode <= goalMode;
    end
  end

  // ==========================================================================
  // Software registers
  always_ff @(posedge clock) begin
    if (srst) begin
      prefetchEnable <= FOP_RST_PIPE_EN;
    end else if (wrOption) begin
      prefetchEnable <= regWrData[FOP_BIT_PIPE_EN];
    end
  end

  // A completed wake leaves the array active so it does not drop straight back
  always_ff @(posedge clock) begin
    if (srst) begin
      powerModeRequest <= FOP_RST_POWER;
    end else if (wakeFinish) begin
      powerModeRequest <= FOP_MODE_ACTIVE;
    end else if (wrPower) begin
      powerModeRequest <= regWrData[FOP_POWER_MSB:FOP_POWER_LSB];
    end
  end

  // ==========================================================================
  // Supply fault capture
  always_ff @(posedge clock) begin
    if (srst) begin
      faultMeta <= 1'b0;
      faultSync <= 1'b0;
    end else begin
      faultMeta <= supplyFaultPin;
      faultSync <= faultMeta;
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      supplyFaultSticky <= FOP_RST_FAULT;
    end else if (faultSync) begin
      supplyFaultSticky <= 1'b1;
    end else if (clearFault) begin
      supplyFaultSticky <= 1'b0;
    end
  end

  // ==========================================================================
  // Read port, one cycle latency; locked reads return zero
  always_ff @(posedge clock) begin
    if (srst) begin
      regRdData <= FOP_RST_RDATA;
    end else if (regRdEn) begin
      regRdData <= accessOk ? readMux : 16'h0000;
    end
  end

  // ==========================================================================
  // Outputs
  assign prefetchPipelineEnable = prefetchEnable;
  assign prefetchActive         = prefetchEnable & fetchInArray;
  assign fetchStall             = wakeNeeded;
  assign powerModeCurrent       = currentMode;

  // ==========================================================================
  // Checks
  logic [10:0] stdbyCycles;
  always_ff @(posedge clock) begin
    if (srst || !sleepToStandbyCounting) begin
      stdbyCycles <= 11'h000;
    end else begin
      stdbyCycles <= stdbyCycles + 11'h001;
    end
  end

  sequence sqOptionWrite;
    wrOption;
  endsequence

  sequence sqStdbyDone;
    $fell(sleepToStandbyCounting);
  endsequence

  AST_PIPE_RESET: assert property (@(posedge clock) srst |=> !prefetchPipelineEnable)
    else $error("pipeline enable not cleared by reset");

  AST_PIPE_WRITE: assert property (@(posedge clock) disable iff (srst)
    sqOptionWrite |=> prefetchPipelineEnable == $past(regWrData[0]))
    else $error("pipeline enable did not follow an unlocked write");

  AST_LOCKED_WRITE: assert property (@(posedge clock) disable iff (srst)
    (regWrEn && !protectedWriteUnlock && !wakeFinish)
      |=> $stable(prefetchEnable) && $stable(powerModeRequest))
    else $error("write without unlock changed a register");

  AST_SECURE_READ: assert property (@(posedge clock) disable iff (srst)
    (regRdEn && securityLocked) |=> regRdData == 16'h0000)
    else $error("read while secured returned data");

  AST_RESERVED_MODE: assert property (@(posedge clock) disable iff (srst)
    (writeOk && hitPower && regWrData[1:0] == 2'h2 && !wakeFinish)
      |=> $stable(powerModeRequest))
    else $error("reserved power code changed the request");

  AST_FAULT_HOLD: assert property (@(posedge clock) disable iff (srst)
    (faultSync || (supplyFaultSticky && !clearFault)) |=> supplyFaultSticky)
    else $error("sticky supply flag lost");

  AST_FAULT_CLEAR: assert property (@(posedge clock) disable iff (srst)
    (clearFault && !faultSync) |=> !supplyFaultSticky)
    else $error("write of one did not clear supply flag");

  AST_STDBY_MODE: assert property (@(posedge clock) disable iff (srst)
    sleepToStandbyCounting |-> powerModeCurrent == 2'h0)
    else $error("mode changed before standby delay elapsed");

  AST_STDBY_LENGTH: assert property (@(posedge clock) disable iff (srst)
    sqStdbyDone |-> powerModeCurrent == 2'h1 && $past(stdbyCycles) == 11'(STDBY_WAIT - 1))
    else $error("standby wait did not last its count");

  AST_ACTIVE_MODE: assert property (@(posedge clock) disable iff (srst)
    $fell(standbyToActiveCounting) |-> powerModeCurrent == 2'h3 && $past(powerModeCurrent) == 2'h1)
    else $error("active reached without standby delay");

  AST_STATUS_READ: assert property (@(posedge clock) disable iff (srst)
    (regRdEn && hitState && accessOk)
      |=> regRdData[3:0] == {$past(standbyToActiveCounting), $past(sleepToStandbyCounting),
                             $past(currentMode)} && regRdData[7:4] == 4'h0)
    else $error("status read did not show live state");

  AST_FETCH_STALL: assert property (@(posedge clock) disable iff (srst)
    (arrayFetch && powerModeCurrent != FOP_MODE_ACTIVE && state == FOP_IDLE)
      |-> fetchStall ##1 (sleepToStandbyCounting || standbyToActiveCounting))
    else $error("array fetch did not stall and start a wake");

endmodule

// File: dv/fop_cpu_model.sv
// CPU-side model of the strobed register port of the flash option bank.
// Assumes the bank samples on the rising edge; this model drives on the falling one.
module fop_cpu_model (
  input  wire logic        clock,
  output logic      [15:0] regAddr,
  output logic             regWrEn,
  output logic             regRdEn,
  output logic      [15:0] regWrData,
  input  wire logic [15:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Idle bus
  initial begin
    regAddr   = 16'h0000;
    regWrEn   = 1'b0;
    regRdEn   = 1'b0;
    regWrData = 16'h0000;
  end

  // ==========================================================================
  // Word transfers
  // Wait-state settings sit outside this bank and are never left at zero
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clock);
    regAddr   = a;
    regWrData = d;
    regWrEn   = 1'b1;
    @(negedge clock);
    regWrEn   = 1'b0;
    // Released lines show a changed value so stale data never passes
    regAddr   = ~a;
    regWrData = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clock);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge clock);
    regRdEn = 1'b0;
    regAddr = ~a;
    @(negedge clock);
    d = regRdData;
  endtask
endmodule

// File: dv/tb_top.sv
// Self-checking bench for the flash option, power and status bank.
// Assumes short transition counts set by parameter and one 25 MHz clock.
module tb_top;
  import fop_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SW = 4;
  localparam int AW = 4;
  logic        clock;
  logic        srst;
  logic [15:0] regAddr;
  logic        regWrEn;
  logic        regRdEn;
  logic [15:0] regWrData;
  logic [15:0] regRdData;
  logic        protectedWriteUnlock;
  logic        securityLocked;
  logic        supplyFaultPin;
  logic        fetchReq;
  logic        fetchInArray;
  logic        fetchStall;
  logic        prefetchActive;
  logic        prefetchPipelineEnable;
  logic [1:0]  powerModeCurrent;
  int          mismatches;
  int          checked;
  int          cyc;
  int          t0;
  logic [15:0] d;
  logic        pipe;

  fop_flash_option_power_regs #(.STDBY_WAIT(SW), .ACTIVE_WAIT(AW))
    fop_flash_option_power_regs_inst (.clock(clock), .srst(srst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .protectedWriteUnlock(protectedWriteUnlock), .securityLocked(securityLocked),
    .supplyFaultPin(supplyFaultPin), .fetchReq(fetchReq), .fetchInArray(fetchInArray),
    .fetchStall(fetchStall), .prefetchActive(prefetchActive),
    .prefetchPipelineEnable(prefetchPipelineEnable), .powerModeCurrent(powerModeCurrent));
  fop_cpu_model fop_cpu_model_inst (.clock(clock), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData));

  // ==========================================================================
  // Clock and helpers
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;

  function automatic logic [15:0] stateExp(logic f, logic a, logic s, logic [1:0] m);
    return {7'h00, f, 4'h0, a, s, m};
  endfunction

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic rc(input string w, input logic [15:0] a, input logic [15:0] e);
    logic [15:0] v;
    fop_cpu_model_inst.rd(a, v);
    chk(w, e, v);
  endtask

  task automatic waitMode(input logic [1:0] m);
    int k;
    for (k = 0; k < 100 && powerModeCurrent !== m; k++) @(negedge clock);
    if (k == 100) begin
      chk("mode wait", 16'(m), 16'(powerModeCurrent));
      report_and_stop();
    end
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    cyc = 0;
    mismatches = 0;
    checked = 0;
    {srst, protectedWriteUnlock, securityLocked} = 3'h4;
    {supplyFaultPin, fetchReq, fetchInArray} = 3'h0;
    void'($urandom(32'h9BFB2758));
    // Count rising edges so the start-up edge of the clock cannot shorten reset
    repeat (2) @(posedge clock);
    @(negedge clock);
    srst = 1'b0;
    rc("option reset", FOP_ADDR_OPTION, 16'h0000);
    rc("power reset", FOP_ADDR_POWER, 16'h0000);
    rc("state reset", FOP_ADDR_STATE, stateExp(0, 0, 0, FOP_MODE_SLEEP));
    fop_cpu_model_inst.wr(FOP_ADDR_OPTION, 16'h0001);
    rc("option locked", FOP_ADDR_OPTION, 16'h0000);
    protectedWriteUnlock = 1'b1;
    securityLocked = 1'b1;
    fop_cpu_model_inst.wr(FOP_ADDR_OPTION, 16'h0001);
    securityLocked = 1'b0;
    rc("option secured", FOP_ADDR_OPTION, 16'h0000);
    fop_cpu_model_inst.wr(16'h0A81, 16'hFFFF);
    rc("unmapped", 16'h0A81, 16'h0000);
    fop_cpu_model_inst.wr(FOP_ADDR_STATE, 16'h00FF);
    rc("state read-only", FOP_ADDR_STATE, stateExp(0, 0, 0, FOP_MODE_SLEEP));
    pipe = 1'b0;
    // Random option writes, some without the unlock
    repeat (10) begin
      d = 16'($urandom);
      protectedWriteUnlock = 1'($urandom);
      if (protectedWriteUnlock) pipe = d[0];
      fop_cpu_model_inst.wr(FOP_ADDR_OPTION, d);
      rc("option", FOP_ADDR_OPTION, {15'h0000, pipe});
      chk("pipe enable", 16'(pipe), 16'(prefetchPipelineEnable));
    end
    protectedWriteUnlock = 1'b1;
    fop_cpu_model_inst.wr(FOP_ADDR_OPTION, 16'h0001);
    securityLocked = 1'b1;
    rc("option read secured", FOP_ADDR_OPTION, 16'h0000);
    securityLocked = 1'b0;
    rc("option read open", FOP_ADDR_OPTION, 16'h0001);
    fetchInArray = 1'b1;
    #1 chk("prefetch on", 16'h0001, 16'(prefetchActive));
    fetchInArray = 1'b0;
    #1 chk("prefetch off", 16'h0000, 16'(prefetchActive));
    fop_cpu_model_inst.wr(FOP_ADDR_POWER, {14'h0000, FOP_MODE_ACTIVE});
    t0 = cyc;
    rc("state stdby wait", FOP_ADDR_STATE, stateExp(0, 0, 1, FOP_MODE_SLEEP));
    waitMode(FOP_MODE_STANDBY);
    chk("stdby time", 16'(SW + 1), 16'(cyc - t0));
    rc("state active wait", FOP_ADDR_STATE, stateExp(0, 1, 0, FOP_MODE_STANDBY));
    waitMode(FOP_MODE_ACTIVE);
    chk("active time", 16'(SW + AW + 2), 16'(cyc - t0));
    rc("state active", FOP_ADDR_STATE, stateExp(0, 0, 0, FOP_MODE_ACTIVE));
    fop_cpu_model_inst.wr(FOP_ADDR_POWER, {14'h0000, FOP_MODE_STANDBY});
    waitMode(FOP_MODE_STANDBY);
    {fetchReq, fetchInArray} = 2'h3;
    #1 chk("fetch stalls", 16'h0001, 16'(fetchStall));
    waitMode(FOP_MODE_ACTIVE);
    chk("stall ends", 16'h0000, 16'(fetchStall));
    // Array quiet before any power write
    {fetchReq, fetchInArray} = 2'h0;
    rc("request forced", FOP_ADDR_POWER, {14'h0000, FOP_MODE_ACTIVE});
    fop_cpu_model_inst.wr(FOP_ADDR_POWER, {14'h0000, FOP_MODE_SLEEP});
    waitMode(FOP_MODE_SLEEP);
    fop_cpu_model_inst.wr(FOP_ADDR_POWER, {14'h0000, FOP_MODE_RESERVED});
    rc("reserved code", FOP_ADDR_POWER, {14'h0000, FOP_MODE_SLEEP});
    chk("mode after reserved", 16'(FOP_MODE_SLEEP), 16'(powerModeCurrent));
    supplyFaultPin = 1'b1;
    repeat (3) @(negedge clock);
    supplyFaultPin = 1'b0;
    repeat (4) @(negedge clock);
    rc("fault latched", FOP_ADDR_STATE, stateExp(1, 0, 0, FOP_MODE_SLEEP));
    fop_cpu_model_inst.wr(FOP_ADDR_STATE, 16'h0000);
    rc("fault zero write", FOP_ADDR_STATE, stateExp(1, 0, 0, FOP_MODE_SLEEP));
    fop_cpu_model_inst.wr(FOP_ADDR_STATE, 16'h0100);
    rc("fault cleared", FOP_ADDR_STATE, stateExp(0, 0, 0, FOP_MODE_SLEEP));
    // Fetch from sleep pays both waits before the stall ends
    {fetchReq, fetchInArray} = 2'h3;
    t0 = cyc;
    #1 chk("sleep fetch stalls", 16'h0001, 16'(fetchStall));
    waitMode(FOP_MODE_ACTIVE);
    chk("wake time", 16'(SW + AW + 2), 16'(cyc - t0));
    chk("sleep stall ends", 16'h0000, 16'(fetchStall));
    {fetchReq, fetchInArray} = 2'h0;
    fop_cpu_model_inst.wr(FOP_ADDR_OPTION, 16'h0001);
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    rc("option second reset", FOP_ADDR_OPTION, 16'h0000);
    rc("power second reset", FOP_ADDR_POWER, 16'h0000);
    rc("state second reset", FOP_ADDR_STATE, stateExp(0, 0, 0, FOP_MODE_SLEEP));
    report_and_stop();
  end
endmodule
